// >>> pkg/fcp_defs.svh
`ifndef FCP_DEFS_SVH
`define FCP_DEFS_SVH

`define FCP_CMD_READ    8'h03
`define FCP_CRC_POLY    32'h04C1_1DB7
`define FCP_CRC_INIT    32'hFFFF_FFFF
`define FCP_IMG_PAD     2'h0
`define FCP_IMG_LOW     20'h0_0000
`define FCP_BW_X1       3'h7
`define FCP_BW_X2       3'h6
`define FCP_BW_X4       3'h5
`define FCP_BW_X8       3'h4
`define FCP_BW_X16      3'h3
`define FCP_WORD_BITS   6'h20
`define FCP_SCK_FALL    2'h0
`define FCP_SCK_SAMPLE  2'h3
`define FCP_ABIT_LAST   5'h1F
`define FCP_IR_IDCODE   4'h1
`define FCP_IR_CAPTURE  4'h1

`endif

// >>> pkg/fcp_pkg.sv
package fcp_pkg;

    typedef enum logic [3:0] {
        S_IDLE = 4'h0, S_CMD  = 4'h1, S_ID   = 4'h2, S_LEN  = 4'h3,
        S_DATA = 4'h4, S_CRC  = 4'h5, S_DONE = 4'h6, S_USER = 4'h7,
        S_ERR  = 4'h8
    } fcp_state_t;

    typedef enum logic [3:0] {
        T_RESET  = 4'h0, T_IDLE   = 4'h1, T_SEL_DR = 4'h2, T_CAP_DR = 4'h3,
        T_SH_DR  = 4'h4, T_EX1_DR = 4'h5, T_PA_DR  = 4'h6, T_EX2_DR = 4'h7,
        T_UPD_DR = 4'h8, T_SEL_IR = 4'h9, T_CAP_IR = 4'hA, T_SH_IR  = 4'hB,
        T_EX1_IR = 4'hC, T_PA_IR  = 4'hD, T_EX2_IR = 4'hE, T_UPD_IR = 4'hF
    } fcp_tap_t;

    typedef struct packed {
        logic o;
        logic oe;
    } fcp_drv_t;

    typedef struct packed {
        logic [31:0] o;
        logic [31:0] oe;
    } fcp_bus_drv_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] data;
    } fcp_word_t;

endpackage

// >>> src/fcp_config_ctrl.sv
`timescale 1ns/1ps
`include "fcp_defs.svh"

// Contract
// - Done line is open drain; reading it high means configured, enter user mode.
// - Reset held low a minimum time; its rising edge restarts configuration.
// - Test port samples TMS and TDI on TCK rise, updates TDO on fall.
// - Undriven TMS and TDI read as one through weak pull-ups.
// - TDI shifts into instruction or data register as the TMS path selects.
// - TDO carries the shifted register and floats when nothing shifts.
// - Three-bit bus width select chooses the configuration data width.
// - Two-bit image select picks the image only when multi-image is enabled.
// - Configuration clock is input when passive, driven output when active.
// - Data bit 0 is passive input or active output; bit 1 the reverse; the code never drives bit 1, which is always an input.
// - All 32 data pins join the shared bus in a parallel chain.
// - Chip select in must stay high; while low the device does not configure.
// - Chip select out enables the next device of a cascade.
// - Error status goes low on ID mismatch, CRC failure or failed update; the code has no update check and flags only ID and CRC failures.
// - Mode select is latched at reset rise: 0 passive, 1 active.
// - In active mode the mode select pin is the flash chip select, low.
// - In user mode the dual-purpose configuration pins are released.
// - Chip select out goes high when the done indication goes high.
module fcp_config_ctrl #(
    parameter logic [31:0] DEVICE_ID = 32'hA5C3_0001  // Arbitrary value.
) (
    input  logic                 clk,
    input  logic                 rst_n,
    input  logic                 config_reset_n,
    input  logic                 config_clock,
    output fcp_pkg::fcp_drv_t    config_clock_drv,
    input  logic [31:0]          config_data_pins,
    output fcp_pkg::fcp_bus_drv_t config_data_drv,
    input  logic                 mode_select_n,
    output fcp_pkg::fcp_drv_t    mode_select_drv,
    input  logic                 config_done_od,
    output fcp_pkg::fcp_drv_t    config_done_drv,
    input  logic                 chip_select_in,
    output logic                 chip_select_out,
    output fcp_pkg::fcp_drv_t    error_status_n_drv,
    input  logic [2:0]           bus_width_select,
    input  logic [1:0]           image_select,
    input  logic                 multi_image_en,
    input  logic                 tck,
    input  logic                 tms,
    input  logic                 tdi,
    output fcp_pkg::fcp_drv_t    tdo_drv,
    output fcp_pkg::fcp_word_t   user_word,
    output logic                 user_mode
);
    import fcp_pkg::*;

    function automatic logic [5:0] width_bits(input logic [2:0] code);
        case (code)
            `FCP_BW_X1:  width_bits = 6'h01;
            `FCP_BW_X2:  width_bits = 6'h02;
            `FCP_BW_X4:  width_bits = 6'h04;
            `FCP_BW_X8:  width_bits = 6'h08;
            `FCP_BW_X16: width_bits = 6'h10;
            default:     width_bits = 6'h20;
        endcase
    endfunction

    function automatic logic [31:0] crc_step(input logic [31:0] c,
                                             input logic [31:0] w);
        logic [31:0] r;
        r = c;
        for (int i = 31; i >= 0; i--) begin
            r = {r[30:0], 1'b0} ^ ((r[31] ^ w[i]) ? `FCP_CRC_POLY : 32'h0);
        end
        return r;
    endfunction

    function automatic fcp_tap_t tap_next(input fcp_tap_t s, input logic m);
        unique case (s)
            T_RESET:  tap_next = m ? T_RESET  : T_IDLE;
            T_IDLE:   tap_next = m ? T_SEL_DR : T_IDLE;
            T_SEL_DR: tap_next = m ? T_SEL_IR : T_CAP_DR;
            T_CAP_DR: tap_next = m ? T_EX1_DR : T_SH_DR;
            T_SH_DR:  tap_next = m ? T_EX1_DR : T_SH_DR;
            T_EX1_DR: tap_next = m ? T_UPD_DR : T_PA_DR;
            T_PA_DR:  tap_next = m ? T_EX2_DR : T_PA_DR;
            T_EX2_DR: tap_next = m ? T_UPD_DR : T_SH_DR;
            T_UPD_DR: tap_next = m ? T_SEL_DR : T_IDLE;
            T_SEL_IR: tap_next = m ? T_RESET  : T_CAP_IR;
            T_CAP_IR: tap_next = m ? T_EX1_IR : T_SH_IR;
            T_SH_IR:  tap_next = m ? T_EX1_IR : T_SH_IR;
            T_EX1_IR: tap_next = m ? T_UPD_IR : T_PA_IR;
            T_PA_IR:  tap_next = m ? T_EX2_IR : T_PA_IR;
            T_EX2_IR: tap_next = m ? T_UPD_IR : T_SH_IR;
            T_UPD_IR: tap_next = m ? T_SEL_DR : T_IDLE;
        endcase
    endfunction

    // Pin synchronisers; stage one is read only by stage two.
    logic [10:0] pin_s1_q, pin_s2_q;
    wire  [10:0] pin_raw = {config_reset_n, chip_select_in, mode_select_n,
                            config_done_od, bus_width_select, image_select,
                            multi_image_en, config_data_pins[1]};
    wire         creset_s = pin_s2_q[10];
    wire         csi_s    = pin_s2_q[9];
    wire         ss_s     = pin_s2_q[8];
    wire         done_s   = pin_s2_q[7];
    wire  [2:0]  bw_s     = pin_s2_q[6:4];
    wire  [1:0]  img_s    = pin_s2_q[3:2];
    wire         mie_s    = pin_s2_q[1];
    wire         miso_s   = pin_s2_q[0];

    fcp_state_t  state_q, state_d;
    logic        creset_prev_q, active_q, pas_en_q;
    logic [2:0]  bw_q;
    logic [31:0] len_q, cnt_q, crc_q;
    fcp_word_t   user_word_q;
    logic [2:0]  tog_s_q;

    // Flash reader of active mode, clocked by clk.
    logic [1:0]  ph_q;
    logic [4:0]  a_cnt_q;
    logic [31:0] a_sh_q, a_word_q;
    logic        a_evt_q, mosi_q;
    fcp_drv_t    cclk_q, ms_q, done_q, err_q, tdo_q;
    logic        cso_q, user_mode_q;

    wire creset_rise = creset_s & ~creset_prev_q;
    wire [1:0] img_sel = mie_s ? img_s : 2'h0;
    wire a_run = active_q &&
                 (state_q inside {S_CMD, S_ID, S_LEN, S_DATA, S_CRC});
    wire a_bit   = (ph_q == `FCP_SCK_SAMPLE);
    wire a_last  = a_bit && (a_cnt_q == `FCP_ABIT_LAST);
    wire [1:0] ph_d = ph_q + 2'h1;
    wire p_evt   = tog_s_q[1] ^ tog_s_q[2];

    // Link-domain shifter for the passive modes. The host clock runs only
    // inside frames, so the enable clears the shifter asynchronously and is
    // released while the link clock stands still; the width code is static
    // from the reset rise on, long before the first link edge of a frame.
    logic [5:0]  lk_cnt_q;
    logic [31:0] lk_sh_q, lk_hold_q;
    logic        lk_tog_q;
    wire  [5:0]  lk_w    = width_bits(bw_q);
    wire  [31:0] lk_mask = (32'h1 << lk_w) - 32'h1;
    wire  [31:0] lk_sh_d = (lk_sh_q << lk_w)
                         | (config_data_pins & lk_mask);
    wire  [5:0]  lk_cnt_d = lk_cnt_q + lk_w;
    wire         lk_full  = (lk_cnt_d == `FCP_WORD_BITS);

    wire         word_evt = active_q ? a_evt_q : p_evt;
    wire  [31:0] word_val = active_q ? a_word_q : lk_hold_q;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            S_IDLE: if (creset_rise && csi_s)
                        state_d = ss_s ? S_CMD : S_ID;
            S_CMD:  if (a_last) state_d = S_ID;
            S_ID:   if (word_evt)
                        state_d = (word_val == DEVICE_ID) ? S_LEN : S_ERR;
            S_LEN:  if (word_evt)
                        state_d = (word_val == 32'h0) ? S_CRC : S_DATA;
            S_DATA: if (word_evt && cnt_q == len_q - 32'h1) state_d = S_CRC;
            S_CRC:  if (word_evt)
                        state_d = (word_val == crc_q) ? S_DONE : S_ERR;
            S_DONE: if (done_s) state_d = S_USER;
            S_USER: state_d = S_USER;
            S_ERR:  state_d = S_ERR;
            default: state_d = S_IDLE;
        endcase
        if (!creset_s) state_d = S_IDLE;
        else if (!csi_s && state_q != S_USER) state_d = S_IDLE;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            tog_s_q  <= '0;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            tog_s_q  <= {tog_s_q[1:0], lk_tog_q};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q       <= S_IDLE;
            creset_prev_q <= 1'b0;
            active_q      <= 1'b0;
            bw_q          <= `FCP_BW_X1;
            pas_en_q      <= 1'b0;
        end else begin
            state_q       <= state_d;
            creset_prev_q <= creset_s;
            pas_en_q <= !active_q && (state_d inside {S_ID, S_LEN, S_DATA,
                                                     S_CRC});
            if (state_q == S_IDLE && creset_rise) begin
                active_q <= ss_s;
                bw_q     <= bw_s;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            len_q       <= '0;
            cnt_q       <= '0;
            crc_q       <= `FCP_CRC_INIT;
            user_word_q <= '0;
        end else begin
            user_word_q.valid <= (state_q == S_DATA) && word_evt;
            if (state_q == S_LEN) begin
                cnt_q <= '0;
                crc_q <= `FCP_CRC_INIT;
                if (word_evt) len_q <= word_val;
            end else if (state_q == S_DATA && word_evt) begin
                cnt_q            <= cnt_q + 32'h1;
                crc_q            <= crc_step(crc_q, word_val);
                user_word_q.data <= word_val;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ph_q     <= '0;
            a_cnt_q  <= '0;
            a_sh_q   <= '0;
            a_word_q <= '0;
            a_evt_q  <= 1'b0;
            mosi_q   <= 1'b0;
        end else begin
            a_evt_q <= a_last && (state_q != S_CMD);
            if (state_q == S_IDLE && creset_rise) begin
                a_sh_q  <= {`FCP_CMD_READ, `FCP_IMG_PAD, img_sel,
                            `FCP_IMG_LOW};
                ph_q    <= '0;
                a_cnt_q <= '0;
            end else if (a_run) begin
                ph_q <= ph_d;
                if (ph_q == `FCP_SCK_FALL) mosi_q <= a_sh_q[31];
                if (a_bit) begin
                    a_sh_q  <= {a_sh_q[30:0], miso_s};
                    a_cnt_q <= a_cnt_q + 5'h1;
                end
                if (a_last) a_word_q <= {a_sh_q[30:0], miso_s};
            end
        end
    end

    // Pin drivers; every dual-purpose configuration pin floats once user mode starts.
    wire in_user = (state_d == S_USER);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cclk_q      <= '0;
            ms_q        <= '0;
            done_q      <= '{o: 1'b0, oe: 1'b1};
            err_q       <= '{o: 1'b1, oe: 1'b1};
            cso_q       <= 1'b0;
            user_mode_q <= 1'b0;
        end else begin
            cclk_q.o    <= a_run && ph_d[1];
            cclk_q.oe   <= a_run;
            ms_q.o      <= 1'b0;
            ms_q.oe     <= a_run;
            done_q.o    <= 1'b0;
            done_q.oe   <= !(state_d inside {S_DONE, S_USER});
            err_q.o     <= (state_d != S_ERR);
            err_q.oe    <= !in_user;
            cso_q       <= in_user;
            user_mode_q <= in_user;
        end
    end

    always_ff @(posedge config_clock or negedge pas_en_q) begin
        if (!pas_en_q) begin
            lk_cnt_q  <= '0;
            lk_sh_q   <= '0;
            lk_hold_q <= '0;
            lk_tog_q  <= 1'b0;
        end else begin
            lk_sh_q  <= lk_sh_d;
            lk_cnt_q <= lk_full ? 6'h00 : lk_cnt_d;
            if (lk_full) begin
                lk_hold_q <= lk_sh_d;
                lk_tog_q  <= ~lk_tog_q;
            end
        end
    end

    // Test port; the pull-ups make an undriven TMS or TDI read as one.
    logic [1:0]  trst_q;
    fcp_tap_t    tap_q;
    logic [3:0]  ir_q, ir_sh_q;
    logic [31:0] dr_sh_q;
    wire ir_is_id = (ir_q == `FCP_IR_IDCODE);
    wire [3:0] ir_sh_d = (tap_q == T_CAP_IR) ? `FCP_IR_CAPTURE :
                         (tap_q == T_SH_IR) ? {tdi, ir_sh_q[3:1]} :
                         ir_sh_q;
    wire [31:0] dr_shift = ir_is_id ? {tdi, dr_sh_q[31:1]} : {31'h0, tdi};
    wire [31:0] dr_sh_d = (tap_q == T_CAP_DR) ?
                          (ir_is_id ? DEVICE_ID : 32'h0) :
                          (tap_q == T_SH_DR) ? dr_shift : dr_sh_q;
    wire [3:0] ir_d = (tap_q == T_RESET) ? `FCP_IR_IDCODE :
                      (tap_q == T_UPD_IR) ? ir_sh_q : ir_q;

    always_ff @(posedge tck) begin
        trst_q <= {trst_q[0], rst_n};
        if (!trst_q[1]) begin
            tap_q   <= T_RESET;
            ir_q    <= `FCP_IR_IDCODE;
            ir_sh_q <= '0;
            dr_sh_q <= '0;
        end else begin
            tap_q   <= tap_next(tap_q, tms);
            ir_q    <= ir_d;
            ir_sh_q <= ir_sh_d;
            dr_sh_q <= dr_sh_d;
        end
    end

    always_ff @(negedge tck) begin
        if (!trst_q[1]) begin
            tdo_q <= '0;
        end else begin
            tdo_q.o  <= (tap_q == T_SH_IR) ? ir_sh_q[0] : dr_sh_q[0];
            tdo_q.oe <= (tap_q == T_SH_IR) || (tap_q == T_SH_DR);
        end
    end

    assign config_clock_drv   = cclk_q;
    assign config_data_drv    = '{o: {31'h0, mosi_q}, oe: {31'h0, cclk_q.oe}};
    assign mode_select_drv    = ms_q;
    assign config_done_drv    = done_q;
    assign error_status_n_drv = err_q;
    assign chip_select_out    = cso_q;
    assign tdo_drv            = tdo_q;
    assign user_word          = user_word_q;
    assign user_mode          = user_mode_q;

endmodule // fcp_config_ctrl

// >>> testbench/fcp_config_ctrl_sva.sv
`timescale 1ns/1ps
module fcp_config_ctrl_sva (
    input logic                  clk,
    input logic                  rst_n,
    input logic                  tck,
    input logic                  config_done_od,
    input fcp_pkg::fcp_drv_t     config_clock_drv,
    input fcp_pkg::fcp_bus_drv_t config_data_drv,
    input fcp_pkg::fcp_drv_t     mode_select_drv,
    input fcp_pkg::fcp_drv_t     config_done_drv,
    input logic                  chip_select_out,
    input fcp_pkg::fcp_drv_t     error_status_n_drv,
    input fcp_pkg::fcp_drv_t     tdo_drv,
    input fcp_pkg::fcp_word_t    user_word,
    input logic                  user_mode
);
    import fcp_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_done_open_drain: assert property (
        config_done_drv.oe |-> !config_done_drv.o) else $error("done driven high");
    a_user_after_done: assert property (
        $rose(user_mode) |-> $past(config_done_od, 2) && config_done_od)
        else $error("user mode without settled done line");
    a_release_in_user: assert property (
        $rose(user_mode) |-> !config_done_drv.oe && !error_status_n_drv.oe &&
        config_data_drv.oe == 32'h0 && !mode_select_drv.oe &&
        !config_clock_drv.oe) else $error("pins still driven in user mode");
    a_cso_follows_user: assert property (
        $rose(user_mode) |-> ##[0:2] chip_select_out) else $error("cso late");
    a_cso_needs_done: assert property (
        $rose(chip_select_out) |-> config_done_od) else $error("cso early");
    a_err_holds_done: assert property (
        error_status_n_drv.oe && !error_status_n_drv.o |->
        config_done_drv.oe && !user_mode) else $error("done freed on error");
    a_flash_cs_low: assert property (
        mode_select_drv.oe |-> !mode_select_drv.o) else $error("flash cs high");
    a_data_bit0_only: assert property (
        config_data_drv.oe[31:1] == 31'h0) else $error("upper data driven");
    a_fclk_shape: assert property (
        $rose(config_clock_drv.o) && config_clock_drv.oe |=>
        (config_clock_drv.o || !config_clock_drv.oe) ##1
        (!config_clock_drv.o || !config_clock_drv.oe))
        else $error("flash clock shape");
    a_tdo_on_fall: assert property (
        $changed(tdo_drv) |-> !tck) else $error("tdo moved with tck high");
    a_word_pulse: assert property (
        user_word.valid |=> !user_word.valid) else $error("word valid stuck");

    cover property ($rose(user_mode));
    cover property ($fell(error_status_n_drv.o));
    cover property ($rose(mode_select_drv.oe));
endmodule // fcp_config_ctrl_sva

bind fcp_config_ctrl fcp_config_ctrl_sva u_sva (.clk, .rst_n, .tck,
    .config_done_od, .config_clock_drv, .config_data_drv, .mode_select_drv,
    .config_done_drv, .chip_select_out, .error_status_n_drv, .tdo_drv,
    .user_word, .user_mode);

// >>> testbench/fcp_cfg_host.sv
`timescale 1ns/1ps
module fcp_cfg_host (
    input  fcp_pkg::fcp_drv_t     clock_drv,
    input  fcp_pkg::fcp_bus_drv_t data_drv,
    input  fcp_pkg::fcp_drv_t     done_drv,
    input  logic                  hold_done,
    output logic                  config_clock,
    output logic [31:0]           config_data_pins,
    output logic                  config_done_od
);
    import fcp_pkg::*;
    logic        link_q = 1'b1;
    logic [31:0] line_q = 32'h0;

    // The host clock idles high between frames, where the pull-up leaves it.
    assign config_clock = clock_drv.oe ? clock_drv.o : link_q;
    assign config_data_pins = {line_q[31:1],
                               data_drv.oe[0] ? data_drv.o[0] : line_q[0]};
    // The factory test input is not modelled: it rests at its pull-up.
    // Pulled-up shared line that any party may hold low.
    assign config_done_od = !(done_drv.oe && !done_drv.o) && !hold_done;

    task automatic pulse(input int n);
        #37;
        repeat (n) begin
            link_q = 1'b0;
            #80;
            link_q = 1'b1;
            #80;
        end
    endtask

    // Idle lines carry the inverse of their last value, not a stale copy.
    task automatic send(input logic [31:0] w, input int bits);
        #37;
        for (int k = 32 / bits - 1; k >= 0; k--) begin
            line_q = ~line_q;
            for (int b = 0; b < bits; b++)
                line_q[b] = w[k * bits + b];
            link_q = 1'b0;
            #80;
            link_q = 1'b1;
            #80;
        end
        line_q = ~line_q;
    endtask
endmodule // fcp_cfg_host

// >>> testbench/test_fcp_config_pin_control.sv
`timescale 1ns/1ps
`include "fcp_defs.svh"
module test_fcp_config_pin_control;
    import fcp_pkg::*;
    localparam logic [31:0] ID_C  = 32'h5A96_0C3E;  // Arbitrary value.
    localparam logic [31:0] PAY_C = 32'hC0DE_1234;
    logic clk = 1'b0, rst_n = 1'b0, config_reset_n = 1'b0, hold_done = 1'b0;
    logic mode_select_n = 1'b0, chip_select_in = 1'b1, multi_image_en = 1'b0;
    logic tck = 1'b0, tms = 1'b1, tdi = 1'b1, bit_q, oe_q;
    logic [2:0]   bus_width_select = `FCP_BW_X1;
    logic [1:0]   image_select = 2'h0;
    logic         config_clock, config_done_od, chip_select_out, user_mode;
    logic [31:0]  config_data_pins, got, oes;
    fcp_drv_t     config_clock_drv, mode_select_drv, config_done_drv;
    fcp_drv_t     error_status_n_drv, tdo_drv;
    fcp_bus_drv_t config_data_drv;
    fcp_word_t    user_word;
    int           failures = 0, compares = 0, words = 0, w0, n;
    logic [31:0]  last_word;

    always #50 clk = ~clk;

    fcp_config_ctrl #(.DEVICE_ID(ID_C)) u_dut (.clk, .rst_n, .config_reset_n,
        .config_clock, .config_clock_drv, .config_data_pins, .config_data_drv,
        .mode_select_n, .mode_select_drv, .config_done_od, .config_done_drv,
        .chip_select_in, .chip_select_out, .error_status_n_drv,
        .bus_width_select, .image_select, .multi_image_en, .tck, .tms, .tdi,
        .tdo_drv, .user_word, .user_mode);
    fcp_cfg_host host (.clock_drv(config_clock_drv), .data_drv(config_data_drv),
        .done_drv(config_done_drv), .hold_done, .config_clock,
        .config_data_pins, .config_done_od);

    always @(posedge clk) begin
        if (user_word.valid === 1'b1) begin
            words++;
            last_word = user_word.data;
        end
    end

    function automatic logic [31:0] crc_of(input logic [31:0] w);
        logic [31:0] c;
        c = `FCP_CRC_INIT;
        for (int i = 31; i >= 0; i--)
            c = (c[31] ^ w[i]) ? {c[30:0], 1'b0} ^ `FCP_CRC_POLY : {c[30:0], 1'b0};
        return c;
    endfunction

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] seen);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Pulses the reconfiguration pin with the straps set up beforehand.
    task automatic cfg(input logic mode, input logic [2:0] width, input logic cs);
        config_reset_n   <= 1'b0;
        mode_select_n    <= mode;
        bus_width_select <= width;
        chip_select_in   <= cs;
        tick(4);
        config_reset_n <= 1'b1;
        tick(10);
        w0 = words;
    endtask

    task automatic stream(input logic [31:0] id, input int bits);
        host.send(id, bits);
        host.send(32'h1, bits);
        host.send(PAY_C, bits);
        host.send(crc_of(PAY_C), bits);
        tick(8);
    endtask

    task automatic tap(input logic m, input logic d);
        tck <= 1'b0;
        tms <= m;
        tdi <= d;
        tick(1);
        bit_q = tdo_drv.o;
        oe_q  = tdo_drv.oe;
        tck <= 1'b1;
        tick(1);
    endtask

    initial begin
        fork
            host.pulse(8);
            repeat (8) begin
                tick(1);
                tck <= ~tck;
            end
        join
        tick(1);
        rst_n <= 1'b1;
        tick(2);
        chk("reset_pins", 5'b11000, {config_done_drv.oe, error_status_n_drv.o,
            chip_select_out, user_mode, tdo_drv.oe});
        $display("test reset done");
        cfg(1'b0, `FCP_BW_X1, 1'b0);
        stream(ID_C, 1);
        chk("unselected", 2'b10, {config_done_drv.oe, user_mode});
        chk("unselected_words", 32'(w0), 32'(words));
        $display("test chip select done");
        multi_image_en <= 1'b1;
        image_select   <= 2'h2;
        cfg(1'b1, `FCP_BW_X1, 1'b1);
        chk("flash_pins", 4'b1011, {mode_select_drv.oe, mode_select_drv.o,
            config_clock_drv.oe, config_data_drv.oe[0]});
        $display("test active mode done");
        cfg(1'b0, `FCP_BW_X8, 1'b1);
        host.send(~ID_C, 8);
        tick(8);
        chk("id_error", 3'b011, {error_status_n_drv.o, error_status_n_drv.oe,
            config_done_drv.oe});
        $display("test id mismatch done");
        cfg(1'b0, `FCP_BW_X1, 1'b1);
        hold_done <= 1'b1;
        stream(ID_C, 1);
        chk("payload_count", 32'(w0 + 1), 32'(words));
        chk("payload", PAY_C, last_word);
        chk("done_released", 2'b01, {config_done_drv.oe, error_status_n_drv.o});
        tick(20);
        chk("held_done", 1'b0, user_mode);
        hold_done <= 1'b0;
        for (n = 0; n < 50 && user_mode !== 1'b1; n++)
            tick(1);
        if (n == 50) begin
            failures++;
            conclude();
        end
        tick(3);
        chk("user_pins", 6'b100000, {chip_select_out, error_status_n_drv.oe,
            |config_data_drv.oe, mode_select_drv.oe, config_clock_drv.oe,
            config_done_drv.oe});
        $display("test load done");
        repeat (5) tap(1'b1, 1'b1);
        tap(1'b0, 1'b1);
        chk("tdo_idle", 1'b0, oe_q);
        tap(1'b1, 1'b1);
        tap(1'b0, 1'b1);
        tap(1'b0, 1'b1);
        for (int i = 0; i < 32; i++) begin
            tap(i == 31, 1'b1);
            got[i] = bit_q;
            oes[i] = oe_q;
        end
        chk("idcode", ID_C, got);
        chk("tdo_shift_oe", 32'hFFFF_FFFF, oes);
        tap(1'b1, 1'b1);
        tap(1'b0, 1'b1);
        tap(1'b0, 1'b1);
        chk("tdo_after", 1'b0, oe_q);
        $display("test test port done");
        conclude();
    end

    initial begin
        #1_000_000;
        failures++;
        conclude();
    end
endmodule // test_fcp_config_pin_control
